// >>> hw/rgbd_pkg.sv
// Purpose: Shared constants for the RGB LED dimming bank control core
// Assumes: 40 MHz mclk, 24 channels grouped in threes
// Notes:   Counts derive from times in their own units
package rgbd_pkg;
  // ==========================================================
  // Geometry
  localparam int NUM_CH      = 24;            // Output channels
  localparam int NUM_MOD     = NUM_CH / 3;    // RGB modules
  localparam int LVL_W       = 8;             // Level width
  localparam int DUTY_W      = 16;            // Product width
  // ==========================================================
  // Reset values
  localparam logic       SLEEP_EN_RST  = 1'b1;   // Auto sleep on by default
  localparam logic       LOG_SEL_RST   = 1'b1;   // Log curve by default
  localparam logic [7:0] MIX_RST       = 8'h00;  // Colour levels start dark
  localparam logic [7:0] DIM_RST       = 8'hff;  // Brightness starts full
  localparam logic [7:0] JOIN_RST      = 8'h00;  // All modules individual
  // ==========================================================
  // Timing
  localparam int CLK_HZ       = 40_000_000;           // mclk rate
  localparam int OFF_TIME_MS  = 30;                   // Off time before sleep
  localparam int OFF_CYCLES   = OFF_TIME_MS * (CLK_HZ / 1000); // Exceed this
  localparam int PWM_CNT_W    = 16;                   // PWM period counter
  localparam logic [15:0] PWM_CNT_MAX = 16'hfe01;     // 255*255 full scale
  // ==========================================================
  // Power state
  typedef enum logic [1:0] {
    RGBD_ST_NORMAL = 2'b01,  // Outputs active
    RGBD_ST_SAVE   = 2'b10   // Power save
  } rgbd_state_t;
endpackage

// >>> hw/rgbd_path.sv
// Purpose: One PWM path: colour times curve-mapped brightness
// Assumes: Levels stable relative to the shared PWM counter
// Notes:   Same path serves channels and the bank
`timescale 1ns/1ps
`default_nettype none
module rgbd_path
  import rgbd_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [LVL_W-1:0]     mix,      // Colour level
  input  wire logic [LVL_W-1:0]     dim,      // Brightness level
  input  wire logic                 log_sel,  // Curve select
  input  wire logic [PWM_CNT_W-1:0] pwm_cnt,  // Shared counter
  output logic      [DUTY_W-1:0]    duty,     // Registered duty
  output logic                      pwm       // Registered output
);
  // ==========================================================
  // Curve mapping
  // Square law approximates a log curve; cheap and monotonic
  function automatic logic [LVL_W-1:0] curve(input logic [LVL_W-1:0] d,
                                             input logic             lg);
    logic [15:0] sq;
    sq = 16'(d) * 16'(d);
    if (lg)
      curve = (d == 8'hff) ? 8'hff : sq[15:8]; // [R8]
    else
      curve = d; // [R8]
  endfunction

  logic [DUTY_W-1:0] duty_next;  // Product before register

  // Colour and brightness act independently as a product
  always_comb
  begin
    duty_next = 16'(mix) * 16'(curve(dim, log_sel)); // [R13] [R7]
  end

  // Duty register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      duty <= 16'h0000;
    else
      duty <= duty_next;
  end

  // Output compare
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pwm <= 1'b0;
    else
      pwm <= (pwm_cnt < duty); // [R11]
  end
endmodule
`default_nettype wire

// >>> hw/rgbd_core.sv
// Purpose: Control core of a 24-channel RGB LED dimming driver
// Assumes: Serial bus decoder writes settings through strobe ports
// Notes:   Registers are loose ports; no address map here
// Function
// [R1] Host configures; twenty-four output channels driven
// [R2] Auto-sleep enable resets to one
// [R3] Enter save after outputs off over 30ms
// [R4] Any addressed bus command leaves save
// [R5] Eight-bit colour level per channel
// [R6] One brightness per three-channel module
// [R7] Brightness has 256 independent steps; here the log curve maps codes 0 to 15 all to zero
// [R8] Curve select: logarithmic or linear brightness
// [R9] Join bit zero: own settings drive module
// [R10] Join bit one: module in bank mode
// [R11] Bank path mirrors channel path structure
// [R12] Bank mode uses bank colours and brightness
// [R13] Duty is colour times mapped brightness
// [R14] Off timer restarts on light or wake
`timescale 1ns/1ps
`default_nettype none
module rgbd_core
  import rgbd_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  bus_cmd,          // Addressed command pulse
  input  wire logic                  sleep_en_wr,      // Write strobe
  input  wire logic                  sleep_en_in,      // Write data
  input  wire logic                  log_sel_wr,       // Write strobe
  input  wire logic                  log_sel_in,       // Write data
  input  wire logic                  join_wr,          // Write strobe
  input  wire logic [NUM_MOD-1:0]    join_in,          // Write data
  input  wire logic                  mix_wr,           // Write strobe
  input  wire logic [4:0]            mix_sel,          // Channel index
  input  wire logic [LVL_W-1:0]      mix_in,           // Colour data
  input  wire logic                  dim_wr,           // Write strobe
  input  wire logic [2:0]            dim_sel,          // Module index
  input  wire logic [LVL_W-1:0]      dim_in,           // Brightness data
  input  wire logic                  bank_mix_wr,      // Write strobe
  input  wire logic [1:0]            bank_mix_sel,     // 0..2 bank colour
  input  wire logic [LVL_W-1:0]      bank_mix_in,      // Bank colour data
  input  wire logic                  bank_dim_wr,      // Write strobe
  input  wire logic [LVL_W-1:0]      bank_dim_in,      // Bank brightness
  output logic      [NUM_CH-1:0]     led_pwm,          // Channel outputs
  output logic                       power_save,       // Save state flag
  output logic                       sleep_en,         // Readback
  output logic                       log_sel,          // Readback
  output logic      [NUM_MOD-1:0]    module_group_join // Readback
);
  // ==========================================================
  // Settings storage
  logic [LVL_W-1:0]     channel_mix_level_reg [NUM_CH];   // Per channel
  logic [LVL_W-1:0]     module_dim_level_reg  [NUM_MOD];  // Per module
  logic [LVL_W-1:0]     bank_mix_reg          [3];        // Bank colours
  logic [LVL_W-1:0]     bank_dim_reg;                     // Bank brightness
  logic                 sleep_en_reg;                     // Auto sleep
  logic                 log_sel_reg;                      // Curve select
  logic [NUM_MOD-1:0]   join_reg;                         // Bank join
  logic [PWM_CNT_W-1:0] pwm_cnt_reg;                      // Shared period
  rgbd_state_t          state_reg;                        // Power state
  logic [31:0]          off_cnt_reg;                      // Off timer
  logic [DUTY_W-1:0]    duty    [NUM_CH];                 // Effective duty
  logic [NUM_CH-1:0]    pwm_raw;                          // Path outputs
  logic [DUTY_W-1:0]    bank_duty [3];                    // Bank path duty
  logic [2:0]           bank_pwm;                         // Bank path outputs
  logic                 all_off;                          // Every duty zero

  // Global controls
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sleep_en_reg <= SLEEP_EN_RST; // [R2]
      log_sel_reg  <= LOG_SEL_RST;
      join_reg     <= JOIN_RST; // [R9]
    end
    else
    begin
      if (sleep_en_wr)
        sleep_en_reg <= sleep_en_in;
      if (log_sel_wr)
        log_sel_reg <= log_sel_in; // [R8]
      if (join_wr)
        join_reg <= join_in; // [R10]
    end
  end

  // Channel colour levels; out-of-range index ignored
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
        channel_mix_level_reg[i] <= MIX_RST;
    end
    else if (mix_wr && (mix_sel < 5'(NUM_CH)))
    begin
      channel_mix_level_reg[mix_sel] <= mix_in; // [R5]
    end
  end

  // Module and bank brightness, bank colours
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int m = 0; m < NUM_MOD; m++)
        module_dim_level_reg[m] <= DIM_RST;
      for (int b = 0; b < 3; b++)
        bank_mix_reg[b] <= MIX_RST;
      bank_dim_reg <= DIM_RST;
    end
    else
    begin
      if (dim_wr)
        module_dim_level_reg[dim_sel] <= dim_in; // [R6]
      if (bank_mix_wr && (bank_mix_sel != 2'h3))
        bank_mix_reg[bank_mix_sel] <= bank_mix_in;
      if (bank_dim_wr)
        bank_dim_reg <= bank_dim_in;
    end
  end

  // Shared PWM period counter
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pwm_cnt_reg <= 16'h0000;
    else if (pwm_cnt_reg >= PWM_CNT_MAX - 16'h0001)
      pwm_cnt_reg <= 16'h0000;
    else
      pwm_cnt_reg <= pwm_cnt_reg + 16'h0001;
  end

  // ==========================================================
  // PWM paths
  // Individual paths, one per channel
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic [DUTY_W-1:0] d_own;  // Own path duty
    rgbd_path u_path (
      .mclk    (mclk),
      .rst     (rst),
      .mix     (channel_mix_level_reg[c]),
      .dim     (module_dim_level_reg[c/3]), // [R6]
      .log_sel (log_sel_reg),
      .pwm_cnt (pwm_cnt_reg),
      .duty    (d_own),
      .pwm     (pwm_raw[c])
    );
    // Bank duty replaces own when joined
    assign duty[c] = join_reg[c/3] ? bank_duty[c%3] : d_own; // [R12]
  end

  // Bank paths, one per colour position
  for (genvar b = 0; b < 3; b++)
  begin : g_bank
    rgbd_path u_bank (
      .mclk    (mclk),
      .rst     (rst),
      .mix     (bank_mix_reg[b]),
      .dim     (bank_dim_reg),
      .log_sel (log_sel_reg),
      .pwm_cnt (pwm_cnt_reg),
      .duty    (bank_duty[b]),
      .pwm     (bank_pwm[b])
    ); // [R11]
  end

  // Off detection across effective duties
  always_comb
  begin
    all_off = 1'b1;
    for (int c = 0; c < NUM_CH; c++)
      if (duty[c] != 16'h0000)
        all_off = 1'b0; // [R13]
  end

  // ==========================================================
  // Power save
  // Timer restarts on light or on wake; saturates past threshold
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      off_cnt_reg <= 32'h0000_0000;
    else if (!all_off || bus_cmd || state_reg == RGBD_ST_SAVE)
      off_cnt_reg <= 32'h0000_0000; // [R14]
    else if (off_cnt_reg <= 32'(OFF_CYCLES))
      off_cnt_reg <= off_cnt_reg + 32'h0000_0001;
  end

  // State: bus command wins over entry
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_reg <= RGBD_ST_NORMAL;
    else
    begin
      case (state_reg)
        RGBD_ST_NORMAL:
        begin
          if (!bus_cmd && sleep_en_reg && all_off && off_cnt_reg > 32'(OFF_CYCLES))
            state_reg <= RGBD_ST_SAVE; // [R3]
        end
        RGBD_ST_SAVE:
        begin
          if (bus_cmd)
            state_reg <= RGBD_ST_NORMAL; // [R4]
        end
        default:
          state_reg <= RGBD_ST_NORMAL;
      endcase
    end
  end

  // ==========================================================
  // Outputs; bank compare selects per module, dark in save
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      led_pwm <= '0;
    else
      for (int c = 0; c < NUM_CH; c++)
        led_pwm[c] <= (state_reg == RGBD_ST_NORMAL) &&
                      (join_reg[c/3] ? bank_pwm[c%3] : pwm_raw[c]); // [R1] [R12]
  end

  assign power_save        = (state_reg == RGBD_ST_SAVE);
  assign sleep_en          = sleep_en_reg;
  assign log_sel           = log_sel_reg;
  assign module_group_join = join_reg;
endmodule
`default_nettype wire

// >>> bench/rgbd_core_assertions.sv
// Purpose: Port checks for the dimming core
// Assumes: One mclk domain, async active-high rst
// Notes:   Dark-run counter bounds save entry
`timescale 1ns/1ps
`default_nettype none
module rgbd_core_chk
  import rgbd_pkg::*;
(
  input wire logic                        mclk,
  input wire logic                        rst,
  input wire logic                        bus_cmd,
  input wire logic                        sleep_en_wr,
  input wire logic                        sleep_en_in,
  input wire logic                        log_sel_wr,
  input wire logic                        log_sel_in,
  input wire logic                        join_wr,
  input wire logic [rgbd_pkg::NUM_MOD-1:0] join_in,
  input wire logic [rgbd_pkg::NUM_CH-1:0]  led_pwm,
  input wire logic                        power_save,
  input wire logic                        sleep_en,
  input wire logic                        log_sel,
  input wire logic [rgbd_pkg::NUM_MOD-1:0] module_group_join
);
  // ==========================================================
  // Dark run: outputs lag duty, so allow a few cycles slack
  localparam int DARK_MIN = OFF_CYCLES - 4;
  logic [31:0] dark_cnt;   // Awake cycles with all outputs low
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      dark_cnt <= '0;
    else if (led_pwm != '0 || bus_cmd || power_save)
      dark_cnt <= '0;
    else
      dark_cnt <= dark_cnt + 32'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Assertions
  sleep_upd_a: assert property (sleep_en_wr |=> sleep_en == $past(sleep_en_in))
    else $error("auto sleep enable not written");
  sleep_hold_a: assert property (!sleep_en_wr |=> $stable(sleep_en))
    else $error("auto sleep enable moved unasked");
  entry_time_a: assert property ($rose(power_save) |-> dark_cnt > DARK_MIN)
    else $error("save entered before dark time");
  entry_en_a: assert property ($rose(power_save) |-> $past(sleep_en))
    else $error("save entered while disabled");
  save_dark_a: assert property (power_save |-> led_pwm == '0)
    else $error("outputs lit in save");
  cmd_wakes_a: assert property (bus_cmd |=> !power_save)
    else $error("bus command did not wake");
  log_upd_a: assert property (log_sel_wr |=> log_sel == $past(log_sel_in))
    else $error("curve select not written");
  log_hold_a: assert property (!log_sel_wr |=> $stable(log_sel))
    else $error("curve select moved unasked");
  join_upd_a: assert property (join_wr |=> module_group_join == $past(join_in))
    else $error("join bits not written");
  join_hold_a: assert property (!join_wr |=> $stable(module_group_join))
    else $error("join bits moved unasked");
  cover property (join_wr && join_in != '0);
  cover property (log_sel_wr && !log_sel_in);
  cover property (bus_cmd && !power_save);
endmodule
bind rgbd_core rgbd_core_chk u_chk (.mclk(mclk), .rst(rst), .bus_cmd(bus_cmd),
  .sleep_en_wr(sleep_en_wr), .sleep_en_in(sleep_en_in), .log_sel_wr(log_sel_wr),
  .log_sel_in(log_sel_in), .join_wr(join_wr), .join_in(join_in), .led_pwm(led_pwm),
  .power_save(power_save), .sleep_en(sleep_en), .log_sel(log_sel),
  .module_group_join(module_group_join));
`default_nettype wire

// >>> bench/rgbd_host_model.sv
// Purpose: Host side writing the core's settings
// Assumes: Strobes held across one rising edge
// Notes:   Data lines inverted once released
`timescale 1ns/1ps
`default_nettype none
module rgbd_host_model
(
  input  wire logic mclk,
  output logic      bus_cmd,
  output logic      sleep_en_wr,
  output logic      sleep_en_in,
  output logic      log_sel_wr,
  output logic      log_sel_in,
  output logic      join_wr,
  output logic      [7:0] join_in,
  output logic      mix_wr,
  output logic      [4:0] mix_sel,
  output logic      [7:0] mix_in,
  output logic      dim_wr,
  output logic      [2:0] dim_sel,
  output logic      [7:0] dim_in,
  output logic      bank_mix_wr,
  output logic      [1:0] bank_mix_sel,
  output logic      [7:0] bank_mix_in,
  output logic      bank_dim_wr,
  output logic      [7:0] bank_dim_in
);
  // ==========================================================
  // Idle bus at time zero
  initial
  begin
    {bus_cmd, sleep_en_wr, log_sel_wr, join_wr, bank_dim_wr, bank_mix_wr, dim_wr, mix_wr} = '0;
    {sleep_en_in, log_sel_in, join_in, mix_sel, mix_in, dim_sel, dim_in} = '0;
    {bank_mix_sel, bank_mix_in, bank_dim_in} = '0;
  end
  // Kind: 0 colour, 1 dim, 2 bank colour, 3 bank dim, 4 join, 5 curve, 6 sleep, 7 command
  task automatic put(input int k, input logic [4:0] s, input logic [7:0] d);
    @(negedge mclk);
    {mix_sel, dim_sel, bank_mix_sel} = {s, s[2:0], s[1:0]};
    {mix_in, dim_in, bank_mix_in, bank_dim_in, join_in} = {5{d}};
    {sleep_en_in, log_sel_in} = {2{d[0]}};
    {bus_cmd, sleep_en_wr, log_sel_wr, join_wr, bank_dim_wr, bank_mix_wr, dim_wr, mix_wr} = 8'h01 << k;
    @(negedge mclk);
    {bus_cmd, sleep_en_wr, log_sel_wr, join_wr, bank_dim_wr, bank_mix_wr, dim_wr, mix_wr} = '0;
    // Released data must not look valid
    {mix_in, dim_in, bank_mix_in, bank_dim_in, join_in} = {5{~d}};
    {sleep_en_in, log_sel_in} = {2{~d[0]}};
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_rgb_led_dimming_bank_control.sv
// Purpose: Self-checking bench for the dimming core
// Assumes: Full-scale duty keeps a channel high all period
// Notes:   Save entry needs 1.2M cycles; left to the checker
`timescale 1ns/1ps
`default_nettype none
module tb_rgb_led_dimming_bank_control;
  import rgbd_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic bus_cmd, sleep_en_wr, sleep_en_in, log_sel_wr, log_sel_in, join_wr, mix_wr;
  logic dim_wr, bank_mix_wr, bank_dim_wr, sleep_en, log_sel, power_save;
  logic [7:0] join_in, mix_in, dim_in, bank_mix_in, bank_dim_in, module_group_join;
  logic [4:0] mix_sel;
  logic [2:0] dim_sel;
  logic [1:0] bank_mix_sel;
  logic [23:0] led_pwm;
  int mismatches = 0;
  int checks_done = 0;
  always #12.5 mclk = ~mclk;
  rgbd_host_model h (.mclk(mclk), .bus_cmd(bus_cmd), .sleep_en_wr(sleep_en_wr),
    .sleep_en_in(sleep_en_in), .log_sel_wr(log_sel_wr), .log_sel_in(log_sel_in),
    .join_wr(join_wr), .join_in(join_in), .mix_wr(mix_wr), .mix_sel(mix_sel),
    .mix_in(mix_in), .dim_wr(dim_wr), .dim_sel(dim_sel), .dim_in(dim_in),
    .bank_mix_wr(bank_mix_wr), .bank_mix_sel(bank_mix_sel), .bank_mix_in(bank_mix_in),
    .bank_dim_wr(bank_dim_wr), .bank_dim_in(bank_dim_in));
  rgbd_core DUT (.mclk(mclk), .rst(rst), .bus_cmd(bus_cmd), .sleep_en_wr(sleep_en_wr),
    .sleep_en_in(sleep_en_in), .log_sel_wr(log_sel_wr), .log_sel_in(log_sel_in),
    .join_wr(join_wr), .join_in(join_in), .mix_wr(mix_wr), .mix_sel(mix_sel),
    .mix_in(mix_in), .dim_wr(dim_wr), .dim_sel(dim_sel), .dim_in(dim_in),
    .bank_mix_wr(bank_mix_wr), .bank_mix_sel(bank_mix_sel), .bank_mix_in(bank_mix_in),
    .bank_dim_wr(bank_dim_wr), .bank_dim_in(bank_dim_in), .led_pwm(led_pwm),
    .power_save(power_save), .sleep_en(sleep_en), .log_sel(log_sel),
    .module_group_join(module_group_join));
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Write-to-output latency is four edges; five leaves margin
  task automatic settle();
    repeat (5) @(negedge mclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(sleep_en, SLEEP_EN_RST);
    chk(log_sel, LOG_SEL_RST);
    chk(module_group_join, JOIN_RST);
    chk({power_save, led_pwm}, 0);
  endtask
  task automatic t_module();
    for (int c = 3; c < 7; c++)
      h.put(0, 5'(c), 8'hff);
    settle();
    chk(led_pwm, 24'h78);
    h.put(1, 5'd1, 8'h00);
    settle();
    chk(led_pwm, 24'h40);
    h.put(1, 5'd1, 8'hff);
    h.put(0, 5'd4, 8'h00);
    h.put(0, 5'd31, 8'hff);
    settle();
    chk(led_pwm, 24'h68);
  endtask
  task automatic t_curve();
    for (int l = 0; l < 2; l++)
    begin
      h.put(5, 5'd0, 8'(l));
      settle();
      chk(log_sel, l);
      chk(led_pwm, 24'h68);
    end
    // Square law maps a low step to zero, so channel 6 goes dark
    h.put(1, 5'd2, 8'h0f);
    settle();
    chk(led_pwm, 24'h28);
    h.put(1, 5'd2, 8'hff);
  endtask
  task automatic t_bank();
    h.put(4, 5'd0, 8'h04);
    settle();
    chk(module_group_join, 8'h04);
    chk(led_pwm, 24'h28);
    h.put(2, 5'd0, 8'hff);
    h.put(2, 5'd2, 8'hff);
    h.put(2, 5'd3, 8'hff);
    settle();
    chk(led_pwm, 24'h168);
    h.put(3, 5'd0, 8'h00);
    settle();
    chk(led_pwm, 24'h28);
    h.put(3, 5'd0, 8'hff);
    h.put(4, 5'd0, 8'h00);
    settle();
    chk(led_pwm, 24'h68);
  endtask
  task automatic t_sleep();
    h.put(7, 5'd0, 8'h00);
    chk(power_save, 0);
    h.put(6, 5'd0, 8'h00);
    chk(sleep_en, 0);
    h.put(6, 5'd0, 8'h01);
    chk(sleep_en, 1);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    t_reset();
    t_module();
    t_curve();
    t_bank();
    t_sleep();
    tally_and_finish();
  end
  // Hang guard
  initial
  begin
    #1ms;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
